// [design/pmd_pkg.sv]
// constants for the per-port phy management register bank
// assumes an axi4-lite master with 32-bit data and word-indexed register slots
package pmd_pkg;
  localparam int AW = 18;
  localparam int NPORT = 2;
  localparam int NDEV = 32;
  localparam int MEM_AW = 2;
  // register indices; byte address = index * 4, per-port index = {port, low index}, irq indices are full 16-bit
  localparam logic [11:0] IDX_SETUP = 12'h11a;
  localparam logic [11:0] IDX_DATA = 12'h11c;
  localparam logic [11:0] IDX_EXT = 12'h11e;
  localparam logic [11:0] IDX_LOOP = 12'h122;
  localparam logic [11:0] IDX_DIAG = 12'h124;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0200;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0201;
  localparam logic [3:0] PORT_FIRST = 4'h1;
  localparam logic [3:0] PORT_LAST = 4'h2;
  // decoded register codes
  localparam logic [2:0] REG_NONE = 3'h0;
  localparam logic [2:0] REG_SETUP = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_EXT = 3'h3;
  localparam logic [2:0] REG_LOOP = 3'h4;
  localparam logic [2:0] REG_DIAG = 3'h5;
  localparam logic [2:0] REG_STAT = 3'h6;
  localparam logic [2:0] REG_MASK = 3'h7;
  // field positions
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 14;
  localparam int DEV_HI = 4;
  localparam int LOOP_BIT = 8;
  localparam int DIAG_EN_BIT = 15;
  localparam int PAIR_HI = 13;
  localparam int PAIR_LO = 12;
  localparam int RES_HI = 9;
  localparam int RES_LO = 8;
  // operation modes of the data window
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_DATA = 2'h1;
  localparam logic [1:0] MODE_INC_RW = 2'h2;
  localparam logic [1:0] MODE_INC_W = 2'h3;
  // reset values and writable masks
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] EXT_VAL = 16'h3000;
  localparam logic [15:0] LOOP_RST = 16'h00f4;
  localparam logic [15:0] LOOP_WMASK = 16'hfffe;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [15:0] DIAG_WMASK = 16'h7c00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DG_IDLE = 2'b01, DG_RUN = 2'b10} pmd_diag_t;
endpackage

// [design/pmd_regs.sv]
// per-port phy management registers: mmd window, extended status, loopback, cable test
// assumes an axi4-lite master and an analog cable tester outside the clock domain
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module pmd_regs
  import pmd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [pmd_pkg::AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [pmd_pkg::AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic irq_out,
  output logic [pmd_pkg::NPORT-1:0] line_loopback_out,
  output logic [pmd_pkg::NPORT-1:0] diag_busy_out,
  output logic [2*pmd_pkg::NPORT-1:0] diag_pair_out,
  input wire logic [pmd_pkg::NPORT-1:0] diag_done_in,
  input wire logic [2*pmd_pkg::NPORT-1:0] diag_result_in
);
  import pmd_pkg::*;

  logic [15:0] setup_reg [NPORT];
  logic [15:0] index_reg [NPORT][NDEV];
  logic [15:0] mmd_mem [NPORT][NDEV][2**MEM_AW];
  logic [15:0] loop_reg [NPORT];
  logic [15:0] diag_ctl_reg [NPORT];
  logic [1:0] diag_res_reg [NPORT];
  pmd_diag_t diag_state_reg [NPORT];
  logic [NPORT-1:0] busy_reg;
  logic [NPORT-1:0] irq_stat_reg;
  logic [NPORT-1:0] irq_stat_next;
  logic [NPORT-1:0] irq_mask_reg;
  logic irq_reg;
  logic [NPORT-1:0] done_s1_reg, done_s2_reg, done_s3_reg;
  logic [2*NPORT-1:0] res_s1_reg, res_s2_reg, res_s3_reg;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic aw_got_reg, w_got_reg, awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg, rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // address decode: port nibble in the top of the index selects the copy
  function automatic logic [2:0] reg_code(input logic [AW-1:0] a);
    logic [15:0] idx;
    logic [3:0] pn;
    idx = a[AW-1:2];
    pn = idx[15:12];
    if (idx == IDX_IRQ_STAT) return REG_STAT;
    if (idx == IDX_IRQ_MASK) return REG_MASK;
    if (pn < PORT_FIRST || pn > PORT_LAST) return REG_NONE;
    unique case (idx[11:0])
      IDX_SETUP: return REG_SETUP;
      IDX_DATA: return REG_DATA;
      IDX_EXT: return REG_EXT;
      IDX_LOOP: return REG_LOOP;
      IDX_DIAG: return REG_DIAG;
      default: return REG_NONE;
    endcase
  endfunction

  function automatic logic reg_port(input logic [AW-1:0] a);
    return a[AW-3]; // nibble 1 -> copy 0, nibble 2 -> copy 1
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nv,
                                          input logic [1:0] strb);
    return {strb[1] ? nv[15:8] : old[15:8], strb[0] ? nv[7:0] : old[7:0]};
  endfunction

  // current value of a register as software sees it
  function automatic logic [15:0] read_word(input logic [2:0] code, input logic p);
    logic [1:0] md;
    logic [4:0] dv;
    logic [15:0] ix;
    md = setup_reg[p][MODE_HI:MODE_LO];
    dv = setup_reg[p][DEV_HI:0];
    ix = index_reg[p][dv];
    unique case (code)
      REG_SETUP: return setup_reg[p];
      REG_DATA: return (md == MODE_REG) ? ix : mmd_mem[p][dv][ix[MEM_AW-1:0]];
      REG_EXT: return EXT_VAL;
      REG_LOOP: return loop_reg[p];
      REG_DIAG: return {busy_reg[p], diag_ctl_reg[p][14:10], diag_res_reg[p], 8'h00};
      REG_STAT: return {{(16-NPORT){1'b0}}, irq_stat_reg};
      REG_MASK: return {{(16-NPORT){1'b0}}, irq_mask_reg};
      default: return 16'h0000;
    endcase
  endfunction

  logic rd_fire, wr_fire;
  logic [2:0] rd_code, wr_code;
  logic rd_p, wr_p;
  logic [1:0] rd_mode, wr_mode;
  logic [4:0] rd_dev, wr_dev;
  logic [15:0] wr_val;
  assign rd_fire = s_axi_arvalid_in && arready_reg;
  // a read taken in the same cycle delays the write by one; keeps index updates single-source
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg && !rd_fire;
  assign rd_code = reg_code(s_axi_araddr_in);
  assign wr_code = reg_code(awaddr_reg);
  assign rd_p = reg_port(s_axi_araddr_in);
  assign wr_p = reg_port(awaddr_reg);
  assign rd_mode = setup_reg[rd_p][MODE_HI:MODE_LO];
  assign wr_mode = setup_reg[wr_p][MODE_HI:MODE_LO];
  assign rd_dev = setup_reg[rd_p][DEV_HI:0];
  assign wr_dev = setup_reg[wr_p][DEV_HI:0];
  assign wr_val = merge16(read_word(wr_code, wr_p), wdata_reg[15:0], wstrb_reg);

  // write channels: address and data taken in either order, response after both
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && awready_reg)
      begin
        awaddr_reg <= s_axi_awaddr_in;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && wready_reg)
      begin
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in[1:0];
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_code == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_reg && s_axi_bready_in)
      begin
        bvalid_reg <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // read channel: data is ready the cycle after the address is taken
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else if (rd_fire)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= (rd_code == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_reg <= {16'h0000, read_word(rd_code, rd_p)};
    end
    else if (rvalid_reg && s_axi_rready_in)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // setup, loopback and cable-test control fields
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        setup_reg[p] <= SETUP_RST;
        loop_reg[p] <= LOOP_RST;
        diag_ctl_reg[p] <= DIAG_RST;
      end
    end
    else if (wr_fire)
    begin
      if (wr_code == REG_SETUP) setup_reg[wr_p] <= wr_val;
      if (wr_code == REG_LOOP) loop_reg[wr_p] <= wr_val & LOOP_WMASK;
      if (wr_code == REG_DIAG) diag_ctl_reg[wr_p] <= wr_val & DIAG_WMASK;
    end
  end

  // mmd space: per-device register index and a small data store behind it
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      for (int p = 0; p < NPORT; p++)
        for (int d = 0; d < NDEV; d++)
        begin
          index_reg[p][d] <= DATA_RST;
          for (int r = 0; r < 2**MEM_AW; r++) mmd_mem[p][d][r] <= DATA_RST;
        end
    end
    else
    begin
      if (wr_fire && wr_code == REG_DATA)
      begin
        if (wr_mode == MODE_REG) index_reg[wr_p][wr_dev] <= wr_val;
        else
        begin
          mmd_mem[wr_p][wr_dev][index_reg[wr_p][wr_dev][MEM_AW-1:0]] <= wr_val;
          if (wr_mode == MODE_INC_RW || wr_mode == MODE_INC_W)
            index_reg[wr_p][wr_dev] <= index_reg[wr_p][wr_dev] + 16'h0001;
        end
      end
      if (rd_fire && rd_code == REG_DATA && rd_mode == MODE_INC_RW)
        index_reg[rd_p][rd_dev] <= index_reg[rd_p][rd_dev] + 16'h0001;
    end
  end

  // done and result come from the analog tester: three stages, act when the last two agree
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      done_s1_reg <= '0;
      done_s2_reg <= '0;
      done_s3_reg <= '0;
      res_s1_reg <= '0;
      res_s2_reg <= '0;
      res_s3_reg <= '0;
    end
    else
    begin
      done_s1_reg <= diag_done_in;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      res_s1_reg <= diag_result_in;
      res_s2_reg <= res_s1_reg;
      res_s3_reg <= res_s2_reg;
    end
  end

  logic [NPORT-1:0] dg_start, dg_abort, dg_done, dg_evt;
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      dg_start[p] = wr_fire && wr_code == REG_DIAG && wr_p == p && wstrb_reg[1]
                    && wdata_reg[DIAG_EN_BIT];
      dg_abort[p] = wr_fire && wr_code == REG_DIAG && wr_p == p && wstrb_reg[1]
                    && !wdata_reg[DIAG_EN_BIT];
      dg_done[p] = done_s2_reg[p] && done_s3_reg[p]
                   && res_s2_reg[2*p +: 2] == res_s3_reg[2*p +: 2];
      dg_evt[p] = diag_state_reg[p] == DG_RUN && dg_done[p] && !dg_abort[p];
    end
  end

  // cable test sequencer; an abort beats a completion landing in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        diag_state_reg[p] <= DG_IDLE;
        diag_res_reg[p] <= 2'h0;
      end
      busy_reg <= '0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        unique case (diag_state_reg[p])
          DG_IDLE:
            if (dg_start[p])
            begin
              diag_state_reg[p] <= DG_RUN;
              busy_reg[p] <= 1'b1;
            end
          DG_RUN:
            if (dg_abort[p])
            begin
              diag_state_reg[p] <= DG_IDLE;
              busy_reg[p] <= 1'b0;
            end
            else if (dg_done[p])
            begin
              diag_state_reg[p] <= DG_IDLE;
              busy_reg[p] <= 1'b0;
              diag_res_reg[p] <= res_s3_reg[2*p +: 2];
            end
          default:
          begin
            diag_state_reg[p] <= DG_IDLE;
            busy_reg[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  // interrupt: sticky completion bits cleared by reading; a new event beats the clear
  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (rd_fire && rd_code == REG_STAT) irq_stat_next = '0;
    irq_stat_next = irq_stat_next | dg_evt;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_fire && wr_code == REG_MASK) irq_mask_reg <= wr_val[NPORT-1:0];
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign irq_out = irq_reg;
  assign diag_busy_out = busy_reg;
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      line_loopback_out[p] = loop_reg[p][LOOP_BIT];
      diag_pair_out[2*p +: 2] = diag_ctl_reg[p][PAIR_HI:PAIR_LO];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [15:0] rd_cur_ix;
  assign rd_cur_ix = index_reg[rd_p][rd_dev];

  index_read_a: assert property (rd_fire && rd_code == REG_DATA && rd_mode == MODE_REG
    |=> s_axi_rdata_out[15:0] == $past(rd_cur_ix)) else $error("index read mismatch");
  data_read_a: assert property (rd_fire && rd_code == REG_DATA && rd_mode != MODE_REG
    |=> s_axi_rdata_out[15:0] == $past(mmd_mem[rd_p][rd_dev][rd_cur_ix[MEM_AW-1:0]]))
    else $error("data read mismatch");
  read_incr_a: assert property (rd_fire && rd_code == REG_DATA && rd_mode == MODE_INC_RW
    |=> index_reg[$past(rd_p)][$past(rd_dev)] == $past(rd_cur_ix) + 16'h0001)
    else $error("index not stepped after read");
  noinc_read_a: assert property (rd_fire && rd_code == REG_DATA && rd_mode == MODE_INC_W
    |=> index_reg[$past(rd_p)][$past(rd_dev)] == $past(rd_cur_ix))
    else $error("index stepped on read in write-only mode");
  ext_status_a: assert property (rd_fire && rd_code == REG_EXT
    |=> s_axi_rdata_out == 32'h0000_3000) else $error("extended status wrong");
  loop_write_a: assert property (wr_fire && wr_code == REG_LOOP && wstrb_reg[1]
    |=> line_loopback_out[$past(wr_p)] == $past(wdata_reg[LOOP_BIT]))
    else $error("loopback not applied");
  diag_start_a: assert property (dg_start[0] && !busy_reg[0]
    |=> diag_busy_out[0] ##1 diag_busy_out[0]) else $error("test did not start");
  diag_abort_a: assert property (dg_abort[1]
    |=> !diag_busy_out[1] && irq_stat_reg[1] == $past(irq_stat_reg[1]))
    else $error("abort ignored");
  busy_read_a: assert property (rd_fire && rd_code == REG_DIAG
    |=> s_axi_rdata_out[DIAG_EN_BIT] == $past(busy_reg[rd_p])) else $error("busy read wrong");
  unmapped_a: assert property (rd_fire && rd_code == REG_NONE
    |=> s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR) else $error("unmapped not refused");
  irq_level_a: assert property (dg_evt[0] && irq_mask_reg[0] |=> irq_out && irq_stat_reg[0])
    else $error("interrupt missing");

  start_cov_c: cover property (dg_start[0] ##[1:200] dg_evt[0]);
  incr_cov_c: cover property (rd_fire && rd_code == REG_DATA && rd_mode == MODE_INC_RW);
  irq_cov_c: cover property ($rose(irq_out));
endmodule

// [tb/pmd_regs_test.sv]
// self-checking bench for the per-port phy management register bank
// assumes pmd_pkg and pmd_regs are compiled first; the bench plays bus master and cable tester
`timescale 1ns/1ps
module pmd_regs_test;
  import pmd_pkg::*;
  typedef struct {
    logic wr;
    logic [17:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0] r;
  } pmd_row_t;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, loop_out, busy, done = 2'h0;
  logic [31:0] rdata;
  logic [3:0] pair, result = 4'h0;
  logic [15:0] rd;
  int fails = 0, total_checks = 0, cycles = 0;
  pmd_row_t rows [26] = '{
    '{1'h0, 18'h04478, 16'h0000, 16'h3000, 2'h0},
    '{1'h1, 18'h04478, 16'hffff, 16'h3000, 2'h0},
    '{1'h0, 18'h08478, 16'h0000, 16'h3000, 2'h0},
    '{1'h0, 18'h04488, 16'h0000, 16'h00f4, 2'h0},
    '{1'h1, 18'h08488, 16'h0101, 16'h0100, 2'h0},
    '{1'h0, 18'h04490, 16'h0000, 16'h0000, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'h0000, 2'h0},
    '{1'h1, 18'h04468, 16'h0003, 16'h0003, 2'h0},
    '{1'h1, 18'h04470, 16'h0005, 16'h0005, 2'h0},
    '{1'h1, 18'h04468, 16'h4003, 16'h4003, 2'h0},
    '{1'h1, 18'h04470, 16'habcd, 16'habcd, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'habcd, 2'h0},
    '{1'h1, 18'h04468, 16'h8003, 16'h8003, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'habcd, 2'h0},
    '{1'h1, 18'h04470, 16'h1111, 16'h0000, 2'h0},
    '{1'h1, 18'h04468, 16'h0003, 16'h0003, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'h0008, 2'h0},
    '{1'h1, 18'h04468, 16'hc003, 16'hc003, 2'h0},
    '{1'h1, 18'h04470, 16'h2222, 16'habcd, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'habcd, 2'h0},
    '{1'h1, 18'h04468, 16'h0003, 16'h0003, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'h0009, 2'h0},
    '{1'h1, 18'h04468, 16'h4004, 16'h4004, 2'h0},
    '{1'h0, 18'h04470, 16'h0000, 16'h0000, 2'h0},
    '{1'h1, 18'h00000, 16'h1234, 16'h0000, 2'h2},
    '{1'h0, 18'h08470, 16'h0000, 16'h0000, 2'h0}
  };

  pmd_regs i_pmd_regs (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq),
    .line_loopback_out(loop_out), .diag_busy_out(busy), .diag_pair_out(pair),
    .diag_done_in(done), .diag_result_in(result)
  );

  always #10 sys_clk_in = ~sys_clk_in;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the closing report
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: response %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: pin %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // address and data offered together; each released at its own handshake edge
  task automatic axi_write(input logic [17:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask

  task automatic axi_read(input logic [17:0] a, input logic [1:0] er);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata[15:0];
    chk_resp(rresp, er);
    chk_data({16'h0000, rdata[31:16]}, 32'h0, "upper half");
  endtask

  // one full cable test on port p; result code k is echoed back by the tester
  task automatic run_diag(input int p, input logic [1:0] k, input logic irq_exp);
    axi_write(18'h04490 + 18'(p * 18'h04000), {4'h8 | 4'(k), 12'h000}, 2'h0);
    chk_pin({3'h0, busy[p]}, 4'h1, "busy");
    chk_pin({2'h0, pair[2*p+:2]}, {2'h0, k}, "pair");
    result[2*p+:2] <= k;
    done[p] <= 1'b1;
    while (busy[p] !== 1'b0)
      @(posedge sys_clk_in);
    axi_read(18'h04490 + 18'(p * 18'h04000), 2'h0);
    chk_data({16'h0, rd}, {16'h0, 2'h0, k, 2'h0, k, 8'h00}, "diag result");
    chk_pin({3'h0, irq}, {3'h0, irq_exp}, "irq");
    axi_read(18'h00800, 2'h0);
    chk_data({16'h0, rd}, 32'(1 << p), "irq status");
    done[p] <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk_pin({3'h0, irq}, 4'h0, "irq cleared");
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    chk_pin({awready, wready, arready, irq}, 4'he, "reset ready irq");
    chk_pin({bvalid, rvalid, loop_out}, 4'h0, "reset valid loop");
    chk_pin({busy, pair[1:0]}, 4'h0, "reset busy");
    rstn_in <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_write(rows[i].a, rows[i].d, rows[i].r);
      axi_read(rows[i].a, rows[i].r);
      chk_data({16'h0, rd}, {16'h0, rows[i].e}, "table row");
    end
    chk_pin({2'h0, loop_out}, 4'h2, "loopback");
    axi_write(18'h00804, 16'h0001, 2'h0);
    for (int k = 0; k < 4; k++)
      run_diag(0, 2'(k), 1'b1);
    // abort on port 2: busy drops, no result and no status bit
    axi_write(18'h08490, 16'hb000, 2'h0);
    chk_pin({2'h0, busy}, 4'h2, "busy p2");
    axi_write(18'h08490, 16'h3000, 2'h0);
    @(posedge sys_clk_in);
    chk_pin({2'h0, busy}, 4'h0, "abort");
    axi_read(18'h00800, 2'h0);
    chk_data({16'h0, rd}, 32'h0, "status after abort");
    run_diag(1, 2'h1, 1'b0);
    // second reset mid-run restores the loopback register
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    axi_read(18'h08488, 2'h0);
    chk_data({16'h0, rd}, 32'h00f4, "loopback after reset");
    chk_pin({2'h0, loop_out}, 4'h0, "loopback pin after reset");
    give_verdict();
  end
endmodule
